// [src/exec_pkg.sv]
// Purpose: shared constants and types for the extend/bitfield/branch execute stage
// Assumes: 32-bit datapath, one clock
// Notes: operation codes are local encodings of the decoder-to-execute link
package exec_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_IDX_W = 4;
  localparam logic [3:0] LINK_REG_IDX = 4'he;
  localparam logic [3:0] SP_REG_IDX = 4'hd;
  localparam logic [3:0] PC_REG_IDX = 4'hf;
  localparam int unsigned POS_W = 5;
  localparam int unsigned WIDTH_W = 6;
  localparam int unsigned ROT_W = 2;
  localparam int unsigned ROT_STEP = 8;
  localparam int unsigned INSN_BYTES = 4;
  // branch reach, in megabytes and in bytes
  localparam int unsigned REACH_FAR_MB = 16;
  localparam int unsigned REACH_NEAR_MB = 1;
  localparam logic signed [31:0] REACH_FAR = 32'sh0100_0000;
  localparam logic signed [31:0] REACH_NEAR = 32'sh0010_0000;

  typedef enum logic [4:0]
  {
    OP_NONE = 5'h00,
    OP_SX_BYTE_ADD = 5'h01,
    OP_SX_HALF_ADD = 5'h02,
    OP_SX_DUAL_ADD = 5'h03,
    OP_ZX_BYTE_ADD = 5'h04,
    OP_ZX_HALF_ADD = 5'h05,
    OP_ZX_DUAL_ADD = 5'h06,
    OP_SX_BYTE = 5'h07,
    OP_SX_HALF = 5'h08,
    OP_ZX_BYTE = 5'h09,
    OP_ZX_HALF = 5'h0a,
    OP_FCLR = 5'h0b,
    OP_FINS = 5'h0c,
    OP_SFX = 5'h0d,
    OP_UFX = 5'h0e,
    OP_JMP = 5'h0f,
    OP_GJMP = 5'h10,
    OP_JAL = 5'h11,
    OP_RJ = 5'h12,
    OP_RJAL = 5'h13
  } exec_op_e;
endpackage

// [src/exec_if.sv]
// Purpose: link between instruction decoder/register file and execute stage
// Assumes: single clock, same-domain logic on both ends
// Notes: one request per cycle when req_valid is high
`timescale 1ns/1ps
interface exec_if;
  // request
  logic req_valid;
  exec_pkg::exec_op_e op;
  logic [1:0] rot_sel;
  logic [4:0] field_lsb;
  logic [5:0] field_width;
  logic guarded;
  logic [3:0] dest_idx;
  logic [3:0] src_idx;
  logic [31:0] first_operand;
  logic [31:0] extend_source;
  logic [31:0] dest_old;
  logic [31:0] pc;
  logic signed [31:0] offset;
  // answer
  logic wr_valid;
  logic [3:0] wr_idx;
  logic [31:0] wr_data;
  logic link_valid;
  logic [31:0] link_data;
  logic jump_valid;
  logic [31:0] jump_target;
  logic bad_use_fault;
  logic range_error;
  logic flags_write;

  modport exec
  (
    input req_valid, op, rot_sel, field_lsb, field_width, guarded, dest_idx, src_idx,
    input first_operand, extend_source, dest_old, pc, offset,
    output wr_valid, wr_idx, wr_data, link_valid, link_data, jump_valid, jump_target,
    output bad_use_fault, range_error, flags_write
  );
  modport core
  (
    output req_valid, op, rot_sel, field_lsb, field_width, guarded, dest_idx, src_idx,
    output first_operand, extend_source, dest_old, pc, offset,
    input wr_valid, wr_idx, wr_data, link_valid, link_data, jump_valid, jump_target,
    input bad_use_fault, range_error, flags_write
  );
endinterface

// [src/exec_unit.sv]
// Purpose: execute stage for extend, extend-and-add, bitfield and jump operations
// Assumes: decoder obeys encoding limits; one request per enabled cycle
// Notes: all answers registered, one cycle after the request is taken
`timescale 1ns/1ps
module exec_unit
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clk_en,
  // decoder / register file link
  exec_if.exec link
);
  // ----------------------------------------
  // operand shaping
  // ----------------------------------------
  logic [31:0] rotated;
  logic [31:0] widened;
  logic [31:0] field_mask;
  logic [31:0] extracted;
  logic [31:0] result;
  logic writes_dest;
  logic [4:0] rot_amt;
  logic [5:0] top_bit;

  always_comb
  begin
    rot_amt = {link.rot_sel, 3'b000};
    // rot_sel of zero is the unrotated case
    rotated = (link.extend_source >> rot_amt)
      | (link.extend_source << (6'd32 - {1'b0, rot_amt}));
    if (link.rot_sel == 2'b00)
    begin
      rotated = link.extend_source;
    end
  end

  always_comb
  begin
    field_mask = 32'hffff_ffff >> (6'd32 - link.field_width);
    field_mask = field_mask << link.field_lsb;
    extracted = (link.extend_source >> link.field_lsb)
      & (32'hffff_ffff >> (6'd32 - link.field_width));
    top_bit = link.field_width - 6'd1;
  end

  always_comb
  begin
    widened = 32'h0000_0000;
    result = 32'h0000_0000;
    writes_dest = 1'b1;
    unique case (link.op)
      exec_pkg::OP_SX_BYTE_ADD, exec_pkg::OP_SX_BYTE:
        widened = {{24{rotated[7]}}, rotated[7:0]};
      exec_pkg::OP_ZX_BYTE_ADD, exec_pkg::OP_ZX_BYTE:
        widened = {24'h00_0000, rotated[7:0]};
      exec_pkg::OP_SX_HALF_ADD, exec_pkg::OP_SX_HALF:
        widened = {{16{rotated[15]}}, rotated[15:0]};
      exec_pkg::OP_ZX_HALF_ADD, exec_pkg::OP_ZX_HALF:
        widened = {16'h0000, rotated[15:0]};
      exec_pkg::OP_SX_DUAL_ADD:
        widened = {{8{rotated[23]}}, rotated[23:16], {8{rotated[7]}}, rotated[7:0]};
      exec_pkg::OP_ZX_DUAL_ADD:
        widened = {8'h00, rotated[23:16], 8'h00, rotated[7:0]};
      default:
        widened = 32'h0000_0000;
    endcase
    unique case (link.op)
      exec_pkg::OP_SX_BYTE_ADD, exec_pkg::OP_ZX_BYTE_ADD, exec_pkg::OP_SX_HALF_ADD,
      exec_pkg::OP_ZX_HALF_ADD:
        result = link.first_operand + widened;
      exec_pkg::OP_SX_DUAL_ADD, exec_pkg::OP_ZX_DUAL_ADD:
        // separate 16-bit sums so the low lane carry is dropped
        result = {16'(link.first_operand[31:16] + widened[31:16]),
                  16'(link.first_operand[15:0] + widened[15:0])};
      exec_pkg::OP_SX_BYTE, exec_pkg::OP_ZX_BYTE, exec_pkg::OP_SX_HALF, exec_pkg::OP_ZX_HALF:
        result = widened;
      exec_pkg::OP_FCLR:
        result = link.dest_old & ~field_mask;
      exec_pkg::OP_FINS:
        result = (link.dest_old & ~field_mask)
          | ((link.extend_source << link.field_lsb) & field_mask);
      exec_pkg::OP_SFX:
        // width 32 leaves nothing to extend; shift pair sign-fills from the field top
        result = 32'($signed(extracted << (6'd31 - top_bit)) >>> (6'd31 - top_bit));
      exec_pkg::OP_UFX:
        result = extracted;
      default:
        writes_dest = 1'b0;
    endcase
  end

  // ----------------------------------------
  // jump forming
  // ----------------------------------------
  logic is_rjump;
  logic is_link;
  logic is_direct;
  logic signed [31:0] reach;
  logic [31:0] next_addr;

  always_comb
  begin
    is_rjump = (link.op == exec_pkg::OP_RJ) || (link.op == exec_pkg::OP_RJAL);
    is_link = (link.op == exec_pkg::OP_JAL) || (link.op == exec_pkg::OP_RJAL);
    is_direct = (link.op == exec_pkg::OP_JMP) || (link.op == exec_pkg::OP_GJMP)
      || (link.op == exec_pkg::OP_JAL);
    next_addr = link.pc + 32'(exec_pkg::INSN_BYTES);
    reach = exec_pkg::REACH_FAR;
    if ((link.op == exec_pkg::OP_GJMP) && !link.guarded)
    begin
      reach = exec_pkg::REACH_NEAR;
    end
  end

  // ----------------------------------------
  // registered answers
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      link.wr_valid <= 1'b0;
      link.wr_idx <= 4'h0;
      link.wr_data <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      link.wr_valid <= link.req_valid && writes_dest;
      link.wr_idx <= link.dest_idx;
      link.wr_data <= result;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      link.link_valid <= 1'b0;
      link.link_data <= 32'h0000_0000;
      link.jump_valid <= 1'b0;
      link.jump_target <= 32'h0000_0000;
      link.bad_use_fault <= 1'b0;
      link.range_error <= 1'b0;
    end
    else if (clk_en)
    begin
      link.link_valid <= 1'b0;
      link.jump_valid <= 1'b0;
      link.bad_use_fault <= 1'b0;
      link.range_error <= 1'b0;
      if (link.req_valid && is_rjump)
      begin
        if (!link.extend_source[0])
        begin
          link.bad_use_fault <= 1'b1;
        end
        else
        begin
          link.jump_valid <= 1'b1;
          link.jump_target <= {link.extend_source[31:1], 1'b0};
          link.link_valid <= is_link;
          link.link_data <= next_addr;
        end
      end
      else if (link.req_valid && is_direct)
      begin
        if ((link.offset >= reach) || (link.offset < -reach))
        begin
          link.range_error <= 1'b1;
        end
        else
        begin
          link.jump_valid <= 1'b1;
          link.jump_target <= link.pc + link.offset;
          link.link_valid <= is_link;
          link.link_data <= next_addr;
        end
      end
    end
  end

  // flag write strobe is never raised by this unit
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      link.flags_write <= 1'b0;
    end
    else if (clk_en)
    begin
      link.flags_write <= 1'b0;
    end
  end
endmodule

// [src/exec_core_side.sv]
// Purpose: decoder/register-file end that issues requests and retires answers
// Assumes: user side supplies decoded fields and register values
// Notes: link write goes to r14; forbidden encodings are dropped, not sent
`timescale 1ns/1ps
module exec_core_side
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clk_en,
  // user request
  input wire logic issue_valid,
  input wire exec_pkg::exec_op_e issue_op,
  input wire logic [1:0] issue_rot,
  input wire logic [4:0] issue_lsb,
  input wire logic [5:0] issue_width,
  input wire logic issue_guarded,
  input wire logic issue_last_in_block,
  input wire logic [3:0] issue_dest,
  input wire logic [3:0] issue_src,
  input wire logic [31:0] issue_first,
  input wire logic [31:0] issue_source,
  input wire logic [31:0] issue_dest_old,
  input wire logic [31:0] issue_pc,
  input wire logic [31:0] issue_offset,
  // user answer
  output logic issue_rejected,
  output logic rf_we,
  output logic [3:0] rf_idx,
  output logic [31:0] rf_data,
  output logic branch_taken,
  output logic [31:0] branch_pc,
  output logic fault,
  // execute link
  exec_if.core link
);
  logic legal;
  logic is_jump;

  always_comb
  begin
    is_jump = issue_op inside {exec_pkg::OP_JMP, exec_pkg::OP_GJMP, exec_pkg::OP_JAL,
      exec_pkg::OP_RJ, exec_pkg::OP_RJAL};
    legal = 1'b1;
    if (!is_jump && (issue_op != exec_pkg::OP_NONE))
    begin
      if ((issue_dest == exec_pkg::SP_REG_IDX) || (issue_dest == exec_pkg::PC_REG_IDX)
        || (issue_src == exec_pkg::SP_REG_IDX) || (issue_src == exec_pkg::PC_REG_IDX))
      begin
        legal = 1'b0;
      end
      // seven-bit sum so that a wide field cannot wrap back into the legal range
      if ((issue_width == 6'd0) || ({2'b00, issue_lsb} + {1'b0, issue_width} > 7'd32))
      begin
        legal = 1'b0;
      end
    end
    if (is_jump && issue_guarded && !issue_last_in_block)
    begin
      legal = 1'b0;
    end
    if ((issue_op == exec_pkg::OP_RJAL) && (issue_src == exec_pkg::PC_REG_IDX))
    begin
      legal = 1'b0;
    end
  end

  // ----------------------------------------
  // request drive
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      link.req_valid <= 1'b0;
      link.op <= exec_pkg::OP_NONE;
      link.rot_sel <= 2'b00;
      link.field_lsb <= 5'h00;
      link.field_width <= 6'h20;
      link.guarded <= 1'b0;
      link.dest_idx <= 4'h0;
      link.src_idx <= 4'h0;
      link.first_operand <= 32'h0000_0000;
      link.extend_source <= 32'h0000_0000;
      link.dest_old <= 32'h0000_0000;
      link.pc <= 32'h0000_0000;
      link.offset <= 32'sh0000_0000;
      issue_rejected <= 1'b0;
    end
    else if (clk_en)
    begin
      link.req_valid <= issue_valid && legal;
      issue_rejected <= issue_valid && !legal;
      link.op <= issue_op;
      link.rot_sel <= issue_rot;
      link.field_lsb <= issue_lsb;
      link.field_width <= issue_width;
      link.guarded <= issue_guarded;
      link.dest_idx <= issue_dest;
      link.src_idx <= issue_src;
      link.first_operand <= issue_first;
      link.extend_source <= issue_source;
      link.dest_old <= issue_dest_old;
      link.pc <= issue_pc;
      link.offset <= issue_offset;
    end
  end

  // ----------------------------------------
  // retire answers
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      rf_we <= 1'b0;
      rf_idx <= 4'h0;
      rf_data <= 32'h0000_0000;
      branch_taken <= 1'b0;
      branch_pc <= 32'h0000_0000;
      fault <= 1'b0;
    end
    else if (clk_en)
    begin
      rf_we <= link.wr_valid || link.link_valid;
      rf_idx <= link.link_valid ? exec_pkg::LINK_REG_IDX : link.wr_idx;
      rf_data <= link.link_valid ? link.link_data : link.wr_data;
      branch_taken <= link.jump_valid;
      branch_pc <= link.jump_target;
      fault <= link.bad_use_fault || link.range_error;
    end
  end
endmodule

// [verification/exec_link_sva.sv]
// Purpose: link checks for the execute end
// Assumes: one clock; every answer lands one enabled edge after its request
// Notes: watches the request fields and checks only what the execute end drives
`timescale 1ns/1ps
module exec_link_sva
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clk_en,
  // request
  input wire logic req_valid,
  input wire exec_pkg::exec_op_e op,
  input wire logic [1:0] rot_sel,
  input wire logic [4:0] field_lsb,
  input wire logic [5:0] field_width,
  input wire logic guarded,
  input wire logic [31:0] first_operand,
  input wire logic [31:0] extend_source,
  input wire logic [31:0] dest_old,
  input wire logic [31:0] pc,
  input wire logic signed [31:0] offset,
  // answer
  input wire logic wr_valid,
  input wire logic [31:0] wr_data,
  input wire logic link_valid,
  input wire logic [31:0] link_data,
  input wire logic jump_valid,
  input wire logic [31:0] jump_target,
  input wire logic bad_use_fault,
  input wire logic range_error,
  input wire logic flags_write
);
  logic [63:0] dbl;
  logic [63:0] fmask;
  logic take;
  logic reg_jump;
  logic [31:0] e_zb, e_sb, e_lane, e_clr, e_tgt;
  // doubling the word turns the right rotate into a plain shift
  assign dbl = {extend_source, extend_source} >> (8 * rot_sel);
  assign fmask = ((64'h1 << field_width) - 64'h1) << field_lsb;
  assign take = req_valid && clk_en;
  assign reg_jump = op == exec_pkg::OP_RJ || op == exec_pkg::OP_RJAL;
  assign e_zb = {24'h00_0000, dbl[7:0]};
  assign e_sb = first_operand + {{24{dbl[7]}}, dbl[7:0]};
  assign e_lane = {first_operand[31:16] + {8'h00, dbl[23:16]},
    first_operand[15:0] + {8'h00, dbl[7:0]}};
  assign e_clr = dest_old & ~fmask[31:0];
  assign e_tgt = {extend_source[31:1], 1'b0};

  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  a_flags_untouched: assert property (!flags_write) else $error("flag write seen");
  a_zero_byte_value: assert property (
    take && op == exec_pkg::OP_ZX_BYTE |=> wr_valid && wr_data == $past(e_zb))
    else $error("zero byte result wrong");
  a_signed_byte_sum: assert property (
    take && op == exec_pkg::OP_SX_BYTE_ADD |=> wr_valid && wr_data == $past(e_sb))
    else $error("signed byte sum wrong");
  a_dual_lane_sum: assert property (
    take && op == exec_pkg::OP_ZX_DUAL_ADD |=> wr_data == $past(e_lane))
    else $error("dual lane sum wrong");
  a_field_clear_value: assert property (
    take && op == exec_pkg::OP_FCLR |=> wr_valid && wr_data == $past(e_clr))
    else $error("field clear wrong");
  a_link_next_addr: assert property (
    take && (op == exec_pkg::OP_JAL && offset < exec_pkg::REACH_FAR
    && offset >= -exec_pkg::REACH_FAR || op == exec_pkg::OP_RJAL && extend_source[0])
    |=> link_valid && link_data == $past(pc) + 32'h0000_0004)
    else $error("link address wrong");
  a_indirect_target: assert property (
    take && reg_jump && extend_source[0] |=> jump_valid && jump_target == $past(e_tgt))
    else $error("indirect target wrong");
  a_even_target_fault: assert property (
    take && reg_jump && !extend_source[0] |=> bad_use_fault && !jump_valid && !link_valid)
    else $error("even target not faulted");
  a_far_reach_limit: assert property (
    take && op == exec_pkg::OP_JMP && offset >= exec_pkg::REACH_FAR
    |=> range_error && !jump_valid)
    else $error("far reach not limited");
  a_near_reach_limit: assert property (
    take && op == exec_pkg::OP_GJMP && !guarded
    && (offset >= exec_pkg::REACH_NEAR || offset < -exec_pkg::REACH_NEAR)
    |=> range_error && !jump_valid)
    else $error("near reach not limited");

  c_dual_lane: cover property (take && op == exec_pkg::OP_SX_DUAL_ADD);
  c_link: cover property (link_valid);
  c_fault: cover property (bad_use_fault);
  c_range: cover property (range_error);
endmodule

// [verification/extend_bitfield_branch_exec_test.sv]
// Purpose: end-to-end test of core side and execute end joined by the link
// Assumes: clk_en held high; inputs change on the falling edge
// Notes: each request gets six cycles to retire before the next one
`timescale 1ns/1ps
module extend_bitfield_branch_exec_test;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic clk_en = 1'b1;
  logic issue_valid, issue_guarded, issue_last_in_block;
  exec_pkg::exec_op_e issue_op;
  logic [1:0] issue_rot;
  logic [4:0] issue_lsb;
  logic [5:0] issue_width;
  logic [3:0] issue_dest, issue_src, rf_idx, s_idx;
  logic [31:0] issue_first, issue_source, issue_dest_old, issue_pc, issue_offset;
  logic [31:0] rf_data, branch_pc, s_data, s_pc, v;
  logic issue_rejected, rf_we, branch_taken, fault, got_rf, got_br, got_f, got_rej;
  logic [4:0] lsbs [5] = '{5'h00, 5'h08, 5'h1f, 5'h14, 5'h09};
  logic [5:0] wids [5] = '{6'h20, 6'h0c, 6'h01, 6'h04, 6'h0a};
  int n_fail = 0;
  int n_checks = 0;

  exec_if link();
  exec_unit u_exec_unit (.clk_sys, .resetn, .clk_en, .link(link));
  exec_core_side u_exec_core_side (.clk_sys, .resetn, .clk_en, .issue_valid, .issue_op,
    .issue_rot, .issue_lsb, .issue_width, .issue_guarded, .issue_last_in_block, .issue_dest,
    .issue_src, .issue_first, .issue_source, .issue_dest_old, .issue_pc, .issue_offset,
    .issue_rejected, .rf_we, .rf_idx, .rf_data, .branch_taken, .branch_pc, .fault, .link(link));
  exec_link_sva u_exec_link_sva (.clk_sys, .resetn, .clk_en, .req_valid(link.req_valid),
    .op(link.op), .rot_sel(link.rot_sel), .field_lsb(link.field_lsb),
    .field_width(link.field_width), .guarded(link.guarded),
    .first_operand(link.first_operand), .extend_source(link.extend_source),
    .dest_old(link.dest_old), .pc(link.pc), .offset(link.offset), .wr_valid(link.wr_valid),
    .wr_data(link.wr_data), .link_valid(link.link_valid), .link_data(link.link_data),
    .jump_valid(link.jump_valid), .jump_target(link.jump_target),
    .bad_use_fault(link.bad_use_fault), .range_error(link.range_error),
    .flags_write(link.flags_write));

  always #5 clk_sys = ~clk_sys;

  // ------
  // tasks
  // ------
  task close_out;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // collects every answer pulse seen while the request retires
  task run(input exec_pkg::exec_op_e o, input logic [31:0] s);
    issue_op = o;
    issue_source = s;
    issue_valid = 1'b1;
    {got_rf, got_br, got_f} = 3'h0;
    s_data = 32'hxxxx_xxxx;
    @(negedge clk_sys);
    issue_valid = 1'b0;
    // the drop pulse stands only in the cycle right after the take edge
    got_rej = issue_rejected;
    repeat (6)
    begin
      @(negedge clk_sys);
      got_rej |= issue_rejected;
      got_br |= branch_taken;
      got_f |= fault;
      if (branch_taken)
        s_pc = branch_pc;
      if (rf_we)
      begin
        got_rf = 1'b1;
        s_idx = rf_idx;
        s_data = rf_data;
      end
    end
  endtask

  task br(input exec_pkg::exec_op_e o, input logic [31:0] s, input logic [31:0] off,
    input logic g, input logic ok, input logic [31:0] tgt);
    issue_offset = off;
    issue_guarded = g;
    run(o, s);
    chk("taken", {31'h0, ok}, {31'h0, got_br});
    chk("fault", {31'h0, ~ok}, {31'h0, got_f});
    if (ok)
      chk("target", tgt, s_pc);
  endtask

  task rej(input exec_pkg::exec_op_e o);
    run(o, 32'h0000_0001);
    chk("rejected", 32'h1, {31'h0, got_rej});
    chk("no answer", 32'h0, {31'h0, got_rf | got_br});
    issue_lsb = 5'h00;
    issue_width = 6'h20;
    issue_dest = 4'h3;
    issue_src = 4'h2;
    issue_last_in_block = 1'b1;
  endtask

  function automatic logic [31:0] ext(input exec_pkg::exec_op_e o, input logic [31:0] s);
    logic [31:0] f;
    f = issue_first;
    case (o)
      exec_pkg::OP_SX_BYTE_ADD: return f + {{24{s[7]}}, s[7:0]};
      exec_pkg::OP_SX_HALF_ADD: return f + {{16{s[15]}}, s[15:0]};
      exec_pkg::OP_SX_DUAL_ADD:
        return {f[31:16] + {{8{s[23]}}, s[23:16]}, f[15:0] + {{8{s[7]}}, s[7:0]}};
      exec_pkg::OP_ZX_BYTE_ADD: return f + {24'h00_0000, s[7:0]};
      exec_pkg::OP_ZX_HALF_ADD: return f + {16'h0000, s[15:0]};
      exec_pkg::OP_ZX_DUAL_ADD:
        return {f[31:16] + {8'h00, s[23:16]}, f[15:0] + {8'h00, s[7:0]}};
      exec_pkg::OP_SX_BYTE: return {{24{s[7]}}, s[7:0]};
      exec_pkg::OP_SX_HALF: return {{16{s[15]}}, s[15:0]};
      exec_pkg::OP_ZX_BYTE: return {24'h00_0000, s[7:0]};
      default: return {16'h0000, s[15:0]};
    endcase
  endfunction

  function automatic logic [31:0] bf(input exec_pkg::exec_op_e o);
    logic [63:0] low;
    logic [31:0] m, x;
    low = (64'h1 << issue_width) - 64'h1;
    m = low[31:0] << issue_lsb;
    x = (issue_source >> issue_lsb) & low[31:0];
    if (o == exec_pkg::OP_FCLR)
      return issue_dest_old & ~m;
    if (o == exec_pkg::OP_FINS)
      return (issue_dest_old & ~m) | ((issue_source << issue_lsb) & m);
    if (o == exec_pkg::OP_SFX && x[issue_width - 1])
      return x | ~low[31:0];
    return x;
  endfunction

  // ------
  // tests
  // ------
  initial
  begin
    #60000;
    n_fail++;
    close_out;
  end

  initial
  begin
    {issue_valid, issue_guarded, issue_last_in_block, issue_rot, issue_lsb} = 10'h080;
    issue_op = exec_pkg::OP_NONE;
    issue_width = 6'h20;
    issue_dest = 4'h3;
    issue_src = 4'h2;
    issue_first = 32'h7fff_ffff;
    issue_source = 32'h0000_0000;
    issue_dest_old = 32'ha5a5_c3c3;
    issue_pc = 32'h0040_0000;
    issue_offset = 32'h0000_0000;
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    resetn = 1'b1;
    for (int k = 1; k <= 10; k++)
      for (int r = 0; r < 4; r++)
      begin
        issue_rot = r[1:0];
        run(exec_pkg::exec_op_e'(k[4:0]), 32'h80f1_7f9c);
        v = (32'h80f1_7f9c >> (8 * r)) | (32'h80f1_7f9c << (32 - 8 * r));
        chk("extend", ext(issue_op, v), s_data);
        chk("dest", {28'h0, issue_dest}, {28'h0, s_idx});
      end
    for (int k = 11; k <= 14; k++)
      for (int i = 0; i < 5; i++)
      begin
        issue_lsb = lsbs[i];
        issue_width = wids[i];
        run(exec_pkg::exec_op_e'(k[4:0]), 32'h9abc_def1);
        chk("field", bf(issue_op), s_data);
      end
    issue_lsb = 5'h1f;
    issue_width = 6'h02;
    rej(exec_pkg::OP_FCLR);
    issue_dest = 4'hd;
    rej(exec_pkg::OP_ZX_BYTE);
    issue_src = 4'hf;
    rej(exec_pkg::OP_RJAL);
    issue_last_in_block = 1'b0;
    issue_guarded = 1'b1;
    rej(exec_pkg::OP_GJMP);
    br(exec_pkg::OP_JMP, 32'h0, 32'h00ff_fffe, 1'b0, 1'b1, 32'h013f_fffe);
    br(exec_pkg::OP_JMP, 32'h0, 32'h0100_0000, 1'b0, 1'b0, 32'h0);
    br(exec_pkg::OP_JMP, 32'h0, 32'hff00_0000, 1'b0, 1'b1, 32'hff40_0000);
    br(exec_pkg::OP_GJMP, 32'h0, 32'h000f_fffe, 1'b0, 1'b1, 32'h004f_fffe);
    br(exec_pkg::OP_GJMP, 32'h0, 32'hfff0_0000, 1'b0, 1'b1, 32'h0030_0000);
    br(exec_pkg::OP_GJMP, 32'h0, 32'h0010_0000, 1'b0, 1'b0, 32'h0);
    br(exec_pkg::OP_GJMP, 32'h0, 32'h0010_0000, 1'b1, 1'b1, 32'h0050_0000);
    br(exec_pkg::OP_RJ, 32'h0000_1235, 32'h0, 1'b0, 1'b1, 32'h0000_1234);
    br(exec_pkg::OP_RJ, 32'hffff_fff1, 32'h0, 1'b0, 1'b1, 32'hffff_fff0);
    br(exec_pkg::OP_RJ, 32'h0000_1234, 32'h0, 1'b0, 1'b0, 32'h0);
    chk("fault", 32'h1, {31'h0, got_f});
    br(exec_pkg::OP_JAL, 32'h0, 32'h0000_0100, 1'b0, 1'b1, 32'h0040_0100);
    chk("link", 32'h0040_0004, s_data);
    chk("link idx", 32'he, {28'h0, s_idx});
    br(exec_pkg::OP_RJAL, 32'h0000_2001, 32'h0, 1'b0, 1'b1, 32'h0000_2000);
    chk("link", 32'h0040_0004, s_data);
    close_out;
  end
endmodule
